//--- verilog/dio_pkg.sv
// How it works
// (R1) Input mode: reads and tests see pins
// (R2) Input mode: write fills latch, drivers off
// (R3) Input mode: swap loads pins, latches accumulator
// (R4) Input mode: pins plus one into latch
// (R5) Input mode: bit write, other bits undefined
// (R6) Output mode: reads and tests see latch
// (R7) Output mode: write fills latch, drives pins
// (R8) Output mode: swap latch with accumulator, drive
// (R9) Output mode: latch plus one, driven
// (R10) Output mode: bit write touches one bit
// (R11) Skip-equal compares pins or latch by mode
// (R12) Arithmetic/logic source is pins or latch
// (R13) Carry bit ops use pin or latch bit
// (R14) Software selects bank before port access
// (R15) Indirect bit address comes from L register
// (R16) Only ports 4 and 5 pair wide
// (R17) Drivers enabled exactly in output mode; code registers pinOe, which follows modeOut one clock later
package dio_pkg;
    localparam int PORT_COUNT = 9;
    localparam int NIB = 4;
    localparam logic [3:0] WIDE_LOW_PORT = 4'h4;
    localparam logic [3:0] LATCH_RESET = 4'h0;
    localparam logic [7:0] ACC_RESET = 8'h00;

    typedef enum logic [4:0] {
        OP_TRANSFER_IN,
        OP_TRANSFER_OUT,
        OP_SWAP,
        OP_BUMP_LATCH,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_TEST_THEN_CLEAR,
        OP_SKIP_IF_SET,
        OP_SKIP_IF_CLEAR,
        OP_BIT_TRANSFER_IN,
        OP_BIT_TRANSFER_OUT,
        OP_BIT_AND,
        OP_BIT_OR,
        OP_BIT_XOR,
        OP_SKIP_IF_EQUAL,
        OP_ADD,
        OP_LOGIC_AND,
        OP_LOGIC_OR,
        OP_LOGIC_XOR
    } dio_op_type;
endpackage

//--- verilog/dio_port_cell.sv
module dio_port_cell (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [3:0] wrData,
    input wire logic outMode,
    output logic [3:0] latchVal,
    output logic [3:0] pinOe
);
    always_ff @(posedge clk) begin
        if (rst) begin
            latchVal <= dio_pkg::LATCH_RESET;
        end else if (wrEn) begin
            latchVal <= wrData;
        end
    end

    // (R17) drivers follow mode
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOe <= 4'h0;
        end else begin
            pinOe <= {4{outMode}};
        end
    end

    property p_oe_mode;
        @(posedge clk) disable iff (rst) 1'b1 |=> (pinOe == {4{$past(outMode)}});
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("driver enable not following mode"); // (R17)
endmodule

//--- verilog/dio_port_bank.sv
module dio_port_bank (
    input wire logic clk,
    input wire logic rst,
    input wire logic opValid,
    input wire dio_pkg::dio_op_type opCode,
    input wire logic [3:0] portSel,
    input wire logic [1:0] bitSel,
    input wire logic useIndirect,
    input wire logic [3:0] lReg,
    input wire logic wide,
    input wire logic [7:0] accIn,
    input wire logic carryIn,
    input wire logic [8:0] modeOut,
    input wire logic [35:0] pinIn,
    output logic respValid,
    output logic [7:0] accOut,
    output logic accLoad,
    output logic carryOut,
    output logic carryLoad,
    output logic skipOut,
    output logic opError,
    output logic [35:0] pinOut,
    output logic [35:0] pinOe
);
    logic [3:0] latchArr [dio_pkg::PORT_COUNT];
    logic [8:0] wrEnVec;
    logic [3:0] wrDataArr [dio_pkg::PORT_COUNT];
    logic isBitOp;
    logic [3:0] portIdx;
    logic [1:0] bitIdx;
    logic portOk;
    logic [3:0] idxSafe;
    logic [3:0] pinLo;
    logic [3:0] readLo;
    logic [3:0] readHi;
    logic [7:0] readVal;
    logic [3:0] bitBase;
    logic [3:0] bitNew;
    logic readBit;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] accOut_next;
    logic accLoad_next;
    logic carryOut_next;
    logic carryLoad_next;
    logic skipOut_next;

    genvar g;
    generate
        for (g = 0; g < dio_pkg::PORT_COUNT; g++) begin : gPort
            dio_port_cell uCell (
                .clk(clk),
                .rst(rst),
                .wrEn(wrEnVec[g]),
                .wrData(wrDataArr[g]),
                .outMode(modeOut[g]),
                .latchVal(latchArr[g]),
                .pinOe(pinOe[g*4 +: 4])
            );
            assign pinOut[g*4 +: 4] = latchArr[g];
        end
    endgenerate

    always_comb begin
        isBitOp = opCode inside {dio_pkg::OP_BIT_SET, dio_pkg::OP_BIT_CLEAR,
            dio_pkg::OP_TEST_THEN_CLEAR, dio_pkg::OP_SKIP_IF_SET, dio_pkg::OP_SKIP_IF_CLEAR,
            dio_pkg::OP_BIT_TRANSFER_IN, dio_pkg::OP_BIT_TRANSFER_OUT, dio_pkg::OP_BIT_AND,
            dio_pkg::OP_BIT_OR, dio_pkg::OP_BIT_XOR};
        // (R15) indirect bit address
        portIdx = (isBitOp && useIndirect) ? {portSel[3:2], lReg[3:2]} : portSel;
        bitIdx = (isBitOp && useIndirect) ? lReg[1:0] : bitSel;
        // (R16) wide only on pair
        portOk = (portIdx < 4'(dio_pkg::PORT_COUNT))
            && !(wide && (portIdx != dio_pkg::WIDE_LOW_PORT))
            && !(wide && (isBitOp || opCode == dio_pkg::OP_BUMP_LATCH));
        idxSafe = portOk ? portIdx : 4'h0;
        pinLo = pinIn[idxSafe*4 +: 4];
        // (R1) (R6) source by mode
        readLo = modeOut[idxSafe] ? latchArr[idxSafe] : pinLo;
        readHi = modeOut[5] ? latchArr[5] : pinIn[20 +: 4];
        readVal = wide ? {readHi, readLo} : {4'h0, readLo};
        readBit = readLo[bitIdx];
        // Input mode base is pins, so the other latch bits pick up pin levels
        bitBase = readLo;
        bitNew = bitBase;
        // (R5) (R10) single bit rewrite
        case (opCode)
            dio_pkg::OP_BIT_SET: bitNew[bitIdx] = 1'b1;
            dio_pkg::OP_BIT_TRANSFER_OUT: bitNew[bitIdx] = carryIn;
            default: bitNew[bitIdx] = 1'b0;
        endcase
        sum9 = {1'b0, accIn} + {1'b0, readVal};
        sum5 = {1'b0, accIn[3:0]} + {1'b0, readLo};
        for (int i = 0; i < dio_pkg::PORT_COUNT; i++) begin
            wrEnVec[i] = 1'b0;
            wrDataArr[i] = latchArr[i];
        end
        accOut_next = accOut;
        accLoad_next = 1'b0;
        carryOut_next = carryOut;
        carryLoad_next = 1'b0;
        skipOut_next = 1'b0;
        if (opValid && portOk) begin
            case (opCode)
                dio_pkg::OP_TRANSFER_IN: begin
                    accOut_next = readVal;
                    accLoad_next = 1'b1;
                end
                // (R2) (R7) accumulator to latch
                dio_pkg::OP_TRANSFER_OUT, dio_pkg::OP_SWAP: begin
                    wrEnVec[idxSafe] = 1'b1;
                    wrDataArr[idxSafe] = accIn[3:0];
                    if (wide) begin
                        wrEnVec[5] = 1'b1;
                        wrDataArr[5] = accIn[7:4];
                    end
                    // (R3) (R8) swap returns source
                    if (opCode == dio_pkg::OP_SWAP) begin
                        accOut_next = readVal;
                        accLoad_next = 1'b1;
                    end
                end
                // (R4) (R9) bump source by one
                dio_pkg::OP_BUMP_LATCH: begin
                    wrEnVec[idxSafe] = 1'b1;
                    wrDataArr[idxSafe] = readLo + 4'h1;
                    skipOut_next = (readLo == 4'hf);
                end
                dio_pkg::OP_BIT_SET, dio_pkg::OP_BIT_CLEAR, dio_pkg::OP_BIT_TRANSFER_OUT: begin
                    wrEnVec[idxSafe] = 1'b1;
                    wrDataArr[idxSafe] = bitNew;
                end
                dio_pkg::OP_TEST_THEN_CLEAR: begin
                    wrEnVec[idxSafe] = 1'b1;
                    wrDataArr[idxSafe] = bitNew;
                    skipOut_next = readBit;
                end
                dio_pkg::OP_SKIP_IF_SET: skipOut_next = readBit;
                dio_pkg::OP_SKIP_IF_CLEAR: skipOut_next = !readBit;
                dio_pkg::OP_BIT_TRANSFER_IN: begin
                    carryOut_next = readBit;
                    carryLoad_next = 1'b1;
                end
                // (R13) carry with pin or latch bit
                dio_pkg::OP_BIT_AND, dio_pkg::OP_BIT_OR, dio_pkg::OP_BIT_XOR: begin
                    carryLoad_next = 1'b1;
                    if (opCode == dio_pkg::OP_BIT_AND) begin
                        carryOut_next = carryIn & readBit;
                    end else if (opCode == dio_pkg::OP_BIT_OR) begin
                        carryOut_next = carryIn | readBit;
                    end else begin
                        carryOut_next = carryIn ^ readBit;
                    end
                end
                // (R11) compare by mode source
                dio_pkg::OP_SKIP_IF_EQUAL: begin
                    skipOut_next = wide ? (accIn == readVal) : (accIn[3:0] == readLo);
                end
                // (R12) accumulator with source
                dio_pkg::OP_ADD: begin
                    accOut_next = wide ? sum9[7:0] : {accIn[7:4], sum5[3:0]};
                    accLoad_next = 1'b1;
                    carryOut_next = wide ? sum9[8] : sum5[4];
                    carryLoad_next = 1'b1;
                end
                dio_pkg::OP_LOGIC_AND: begin
                    accOut_next = wide ? (accIn & readVal) : {accIn[7:4], accIn[3:0] & readLo};
                    accLoad_next = 1'b1;
                end
                dio_pkg::OP_LOGIC_OR: begin
                    accOut_next = wide ? (accIn | readVal) : {accIn[7:4], accIn[3:0] | readLo};
                    accLoad_next = 1'b1;
                end
                dio_pkg::OP_LOGIC_XOR: begin
                    accOut_next = wide ? (accIn ^ readVal) : {accIn[7:4], accIn[3:0] ^ readLo};
                    accLoad_next = 1'b1;
                end
                default: accLoad_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            respValid <= 1'b0;
            opError <= 1'b0;
        end else begin
            respValid <= opValid;
            opError <= opValid && !portOk;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            accOut <= dio_pkg::ACC_RESET;
            accLoad <= 1'b0;
            carryOut <= 1'b0;
            carryLoad <= 1'b0;
            skipOut <= 1'b0;
        end else begin
            accOut <= accOut_next;
            accLoad <= accLoad_next;
            carryOut <= carryOut_next;
            carryLoad <= carryLoad_next;
            skipOut <= skipOut_next;
        end
    end

    logic narrowGo;
    assign narrowGo = opValid && portOk && !wide;

    property p_read_pins;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_TRANSFER_IN && !modeOut[portIdx]
        |=> accLoad && accOut[3:0] == $past(pinLo);
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("input read not from pins"); // (R1)

    property p_read_latch;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_TRANSFER_IN && modeOut[portIdx]
        |=> accOut[3:0] == $past(latchArr[portIdx]);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("output read not from latch"); // (R6)

    property p_write_out;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_TRANSFER_OUT
        |=> pinOut[$past(portIdx)*4 +: 4] == $past(accIn[3:0]);
    endproperty
    a_write_out: assert property (p_write_out) else $error("write did not reach latch"); // (R7)

    property p_write_off;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_TRANSFER_OUT && !modeOut[portIdx]
        && $stable(modeOut) ##1 $stable(modeOut)
        |=> pinOe[$past(portIdx, 2)*4 +: 4] == 4'h0;
    endproperty
    a_write_off: assert property (p_write_off) else $error("drivers on in input mode"); // (R2)

    property p_bump_in;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_BUMP_LATCH && !modeOut[portIdx]
        |=> latchArr[$past(portIdx)] == $past(pinLo) + 4'h1;
    endproperty
    a_bump_in: assert property (p_bump_in) else $error("bump not from pins"); // (R4)

    property p_bump_out;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_BUMP_LATCH && modeOut[portIdx]
        |=> latchArr[$past(portIdx)] == $past(latchArr[portIdx]) + 4'h1;
    endproperty
    a_bump_out: assert property (p_bump_out) else $error("bump not from latch"); // (R9)

    property p_swap_in;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_SWAP && !modeOut[portIdx]
        |=> accOut[3:0] == $past(pinLo) && latchArr[$past(portIdx)] == $past(accIn[3:0]);
    endproperty
    a_swap_in: assert property (p_swap_in) else $error("swap in input mode wrong"); // (R3)

    property p_skip_eq;
        @(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_SKIP_IF_EQUAL
        |=> skipOut == ($past(accIn[3:0]) == $past(readLo));
    endproperty
    a_skip_eq: assert property (p_skip_eq) else $error("skip-equal wrong"); // (R11)

    property p_bit_and;
        @(posedge clk) disable iff (rst)
        opValid && portOk && opCode == dio_pkg::OP_BIT_AND && !modeOut[portIdx]
        |=> carryLoad && carryOut == ($past(carryIn) & $past(pinLo[bitIdx]));
    endproperty
    a_bit_and: assert property (p_bit_and) else $error("carry and not on pin bit"); // (R13)

    property p_wide_err;
        @(posedge clk) disable iff (rst)
        opValid && wide && portSel != dio_pkg::WIDE_LOW_PORT && !isBitOp
        |=> opError && !accLoad;
    endproperty
    a_wide_err: assert property (p_wide_err) else $error("wide access outside pair"); // (R16)

    c_wide_read: cover property (@(posedge clk) disable iff (rst)
        opValid && wide && portOk && opCode == dio_pkg::OP_TRANSFER_IN);
    c_indirect: cover property (@(posedge clk) disable iff (rst)
        opValid && useIndirect && portOk && opCode == dio_pkg::OP_BIT_SET);
    c_swap_out: cover property (@(posedge clk) disable iff (rst)
        narrowGo && opCode == dio_pkg::OP_SWAP && modeOut[portIdx]);
endmodule

//--- tb/dio_pin_driver.sv
module dio_pin_driver (
    input wire logic [35:0] pinOut,
    input wire logic [35:0] pinOe,
    input wire logic [35:0] extVal,
    output logic [35:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // enabled drivers win
    // Outside circuit keeps driving its own level on pins left undriven
    always_comb begin
        for (int i = 0; i < 36; i++) begin
            pinIn[i] = pinOe[i] ? pinOut[i] : extVal[i];
        end
    end
endmodule

//--- tb/digital_io_port_access_bench.sv
`define CHK(nm, e, g) begin \
    numChecks++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
end
module digital_io_port_access_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, opValid, useIndirect, wide, carryIn;
    logic respValid, accLoad, carryOut, carryLoad, skipOut, opError;
    dio_pkg::dio_op_type opCode;
    logic [3:0] portSel, lReg;
    logic [1:0] bitSel;
    logic [7:0] accIn, accOut;
    logic [8:0] modeOut;
    logic [35:0] pinIn, extVal, pinOut, pinOe, expOe, expLat;
    logic [3:0] lat [0:8];
    int miscompares, numChecks;

    dio_port_bank dio_port_bank_i (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode),
        .portSel(portSel), .bitSel(bitSel), .useIndirect(useIndirect), .lReg(lReg),
        .wide(wide), .accIn(accIn), .carryIn(carryIn), .modeOut(modeOut), .pinIn(pinIn),
        .respValid(respValid), .accOut(accOut), .accLoad(accLoad), .carryOut(carryOut),
        .carryLoad(carryLoad), .skipOut(skipOut), .opError(opError), .pinOut(pinOut),
        .pinOe(pinOe));
    dio_pin_driver dio_pin_driver_i (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
        .pinIn(pinIn));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [3:0] src(int p);
        return modeOut[p] ? lat[p] : extVal[4*p +: 4];
    endfunction

    task automatic complete_run();
        $display("checks %0d miscompares %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic setMode(logic [8:0] m);
        @(negedge clk);
        modeOut = m;
        @(posedge clk);
    endtask

    // bank assumed selected; ports addressed directly, or through lReg for bit ops with ind set
    task automatic runOp(dio_pkg::dio_op_type op, logic [3:0] p, logic [1:0] b, logic ind,
            logic w, logic [7:0] acc, logic cy);
        logic [3:0] s, s5, n;
        logic [7:0] eAcc;
        logic eSkip, eCy, bad, ld, cl, wrt, bitOp;
        bitOp = op >= dio_pkg::OP_BIT_SET && op <= dio_pkg::OP_BIT_XOR;
        ind = ind & bitOp;
        bad = p > 8 || (w && (p != 4 || bitOp || op == dio_pkg::OP_BUMP_LATCH));
        @(negedge clk);
        extVal = 36'({$urandom, $urandom});
        opValid = 1'b1;
        opCode = op;
        // low port bits and bit come from lReg
        portSel = ind ? {p[3:2], ~p[1:0]} : p;
        bitSel = ind ? ~b : b;
        useIndirect = ind;
        lReg = ind ? {p[1:0], b} : 4'($urandom);
        wide = w;
        accIn = acc;
        carryIn = cy;
        s = bad ? 4'h0 : src(p);
        s5 = src(5);
        n = s;
        eAcc = {4'h0, s};
        {eSkip, eCy, ld, cl, wrt} = {1'b0, cy, 3'b000};
        case (op)
            dio_pkg::OP_TRANSFER_IN: begin
                ld = 1'b1;
                eAcc = w ? {s5, s} : {4'h0, s};
            end
            dio_pkg::OP_TRANSFER_OUT: {wrt, n} = {1'b1, acc[3:0]};
            dio_pkg::OP_SWAP: begin
                ld = 1'b1;
                eAcc = w ? {s5, s} : {4'h0, s};
                {wrt, n} = {1'b1, acc[3:0]};
            end
            dio_pkg::OP_BUMP_LATCH: begin
                {wrt, n} = {1'b1, s + 4'h1};
                eSkip = n == 4'h0;
            end
            dio_pkg::OP_BIT_SET: {wrt, n[b]} = 2'b11;
            dio_pkg::OP_BIT_CLEAR: {wrt, n[b]} = 2'b10;
            dio_pkg::OP_TEST_THEN_CLEAR: {wrt, n[b], eSkip} = {2'b10, s[b]};
            dio_pkg::OP_SKIP_IF_SET: eSkip = s[b];
            dio_pkg::OP_SKIP_IF_CLEAR: eSkip = !s[b];
            dio_pkg::OP_BIT_TRANSFER_IN: {cl, eCy} = {1'b1, s[b]};
            dio_pkg::OP_BIT_TRANSFER_OUT: {wrt, n[b]} = {1'b1, cy};
            dio_pkg::OP_BIT_AND: {cl, eCy} = {1'b1, cy & s[b]};
            dio_pkg::OP_BIT_OR: {cl, eCy} = {1'b1, cy | s[b]};
            dio_pkg::OP_BIT_XOR: {cl, eCy} = {1'b1, cy ^ s[b]};
            dio_pkg::OP_SKIP_IF_EQUAL: eSkip = w ? acc == {s5, s} : acc[3:0] == s;
            dio_pkg::OP_ADD: begin
                {ld, cl} = 2'b11;
                {eCy, eAcc[3:0]} = {1'b0, acc[3:0]} + {1'b0, s};
                eAcc[7:4] = acc[7:4];
                if (w) {eCy, eAcc} = {1'b0, acc} + {1'b0, s5, s};
            end
            dio_pkg::OP_LOGIC_AND: {ld, eAcc} = {1'b1, acc & (w ? {s5, s} : {4'hf, s})};
            dio_pkg::OP_LOGIC_OR: {ld, eAcc} = {1'b1, acc | (w ? {s5, s} : {4'h0, s})};
            default: {ld, eAcc} = {1'b1, acc ^ (w ? {s5, s} : {4'h0, s})};
        endcase
        @(posedge clk);
        @(negedge clk);
        opValid = 1'b0;
        `CHK("respValid", 1'b1, respValid)
        `CHK("opError", bad, opError)
        if (!bad) begin
            if (ld) `CHK("accOut", eAcc, accOut)
            `CHK("accLoad", ld, accLoad)
            `CHK("skipOut", eSkip, skipOut)
            if (cl) `CHK("carryOut", eCy, carryOut)
            `CHK("carryLoad", cl, carryLoad)
            if (wrt && w) {lat[5], lat[4]} = acc;
            else if (wrt) lat[p] = n;
        end
        for (int i = 0; i < 9; i++) begin
            expLat[4*i +: 4] = lat[i];
            expOe[4*i +: 4] = {4{modeOut[i]}};
        end
        `CHK("pinOut", expLat, pinOut)
        `CHK("pinOe", expOe, pinOe)
    endtask

    initial begin
        {rst, opValid, useIndirect, wide, carryIn} = 5'b10000;
        {portSel, lReg, bitSel, accIn, modeOut, extVal} = '0;
        opCode = dio_pkg::OP_TRANSFER_IN;
        void'($urandom(32'h86d9d70f));
        for (int i = 0; i < 9; i++) lat[i] = dio_pkg::LATCH_RESET;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int m = 0; m < 2; m++) begin
            setMode({9{m[0]}});
            for (int k = 0; k < 19; k++) begin
                runOp(dio_pkg::dio_op_type'(k), 4'($urandom_range(0, 8)), 2'($urandom),
                    1'($urandom), 1'b0, 8'($urandom), 1'($urandom));
            end
        end
        $display("test sweep done");
        setMode(9'h030);
        for (int k = 0; k < 3; k++) begin
            runOp(dio_pkg::OP_TRANSFER_OUT, 4'h4, 2'h0, 1'b0, 1'b1, 8'($urandom), 1'b0);
            runOp(dio_pkg::OP_SKIP_IF_EQUAL, 4'h4, 2'h0, 1'b0, 1'b1, {lat[5], lat[4]}, 1'b0);
            runOp(dio_pkg::OP_SWAP, 4'h4, 2'h0, 1'b0, 1'b1, 8'($urandom), 1'b0);
            runOp(dio_pkg::OP_TRANSFER_IN, 4'h4, 2'h0, 1'b0, 1'b1, 8'h00, 1'b0);
            runOp(dio_pkg::OP_ADD, 4'h4, 2'h0, 1'b0, 1'b1, 8'($urandom), 1'b0);
            runOp(dio_pkg::dio_op_type'($urandom_range(16, 18)), 4'h4, 2'h0, 1'b0, 1'b1,
                8'($urandom), 1'b0);
            runOp(dio_pkg::OP_TRANSFER_OUT, 4'h5, 2'h0, 1'b0, 1'b0, 8'h0f, 1'b0);
            runOp(dio_pkg::OP_BUMP_LATCH, 4'h5, 2'h0, 1'b0, 1'b0, 8'h00, 1'b0);
            setMode(9'h000);
        end
        $display("test wide done");
        runOp(dio_pkg::OP_TRANSFER_OUT, 4'h9, 2'h0, 1'b0, 1'b0, 8'h5a, 1'b0);
        runOp(dio_pkg::OP_TRANSFER_OUT, 4'hf, 2'h0, 1'b0, 1'b0, 8'h5a, 1'b0);
        runOp(dio_pkg::OP_TRANSFER_OUT, 4'h2, 2'h0, 1'b0, 1'b1, 8'h5a, 1'b0);
        runOp(dio_pkg::OP_BIT_SET, 4'h4, 2'h1, 1'b0, 1'b1, 8'h00, 1'b0);
        runOp(dio_pkg::OP_BUMP_LATCH, 4'h4, 2'h0, 1'b0, 1'b1, 8'h00, 1'b0);
        $display("test refused done");
        for (int k = 0; k < 400; k++) begin
            if (k % 25 == 0) setMode(9'($urandom));
            runOp(dio_pkg::dio_op_type'($urandom_range(0, 18)), 4'($urandom_range(0, 8)),
                2'($urandom), 1'($urandom), 1'b0, 8'($urandom), 1'($urandom));
        end
        $display("test random done");
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
